// File: hdl/pspi_pkg.sv
/*
 Constants, register map and carrier types for the position settle and pulse inhibit block.
 Assumes a single 10 MHz drive clock and pulse inputs that are already synchronous to it.
*/
`default_nettype none
package pspi_pkg;
   typedef struct packed
   {
      logic pulse;
      logic dir;
   } pspi_pulse_t;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RESTART = 8'h04;
   localparam logic [7:0] OFS_ACCEL = 8'h08;
   localparam logic [7:0] OFS_AVG = 8'h0C;
   localparam logic [7:0] OFS_DONE_W = 8'h10;
   localparam logic [7:0] OFS_NEAR_W = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_ERROR = 8'h1C;
   localparam logic [7:0] OFS_INT_STAT = 8'h20;
   localparam logic [7:0] OFS_INT_MASK = 8'h24;

   localparam int CTRL_METHOD_LSB = 0;
   localparam int CTRL_TIMING_LSB = 4;
   localparam int CTRL_ALLOC_BIT = 8;
   localparam int RESTART_BIT = 0;

   localparam int ST_DONE = 0;
   localparam int ST_NEAR = 1;
   localparam int ST_INHIBIT = 2;
   localparam int ST_FORCE = 3;
   localparam int ST_POS = 4;
   localparam int ST_PENDING = 5;
   localparam int ST_METHOD_LSB = 8;
   localparam int ST_TIMING_LSB = 12;
   localparam int ST_ALLOC = 14;

   localparam int INT_DONE = 0;
   localparam int INT_NEAR = 1;
   localparam int INT_BLOCKED = 2;
   localparam int INT_APPLIED = 3;

   localparam logic [3:0] M_POS = 4'h1;
   localparam logic [3:0] M_FORCE = 4'h2;
   localparam logic [3:0] M_ISP_POS = 4'h5;
   localparam logic [3:0] M_POS_SPD = 4'h7;
   localparam logic [3:0] M_POS_FRC = 4'h8;
   localparam logic [3:0] M_POS_INH = 4'hB;

   localparam logic [1:0] T_WIDTH = 2'h0;
   localparam logic [1:0] T_FILTER = 2'h1;
   localparam logic [1:0] T_INPUT = 2'h2;

   localparam logic [3:0] METHOD_RST = 4'h1;
   localparam logic [1:0] TIMING_RST = 2'h0;
   localparam logic [15:0] TC_RST = 16'h0000;
   localparam logic [30:0] DONE_W_RST = 31'h00000007;
   localparam logic [30:0] NEAR_W_RST = 31'h40000000;

   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_NS = 1000000;
   localparam int STOP_CYCLES = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pspi_pkg
`default_nettype wire

// File: hdl/pspi_settle.sv
/*
 Position settle and pulse inhibit block: smoothing, error counting, done and near outputs.
 Assumes an APB master, pulse inputs synchronous to CLK and one unit of travel per FB pulse.
*/
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module pspi_settle
#(
   parameter int STOP_CYCLES = pspi_pkg::STOP_CYCLES
)
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire pspi_pkg::pspi_pulse_t REF_IN,
   input wire pspi_pkg::pspi_pulse_t FB_IN,
   input wire logic PCON_IN,
   input wire logic INHIBIT_IN,
   input wire logic CSEL_IN,
   output var pspi_pkg::pspi_pulse_t FILT_OUT,
   output logic DONE_OUT,
   output logic NEAR_OUT,
   output logic FORCE_OUT,
   output logic IRQ
);
   logic [3:0] method_cfg;
   logic [3:0] method_act;
   logic [1:0] timing_cfg;
   logic [1:0] timing_act;
   logic alloc_cfg;
   logic alloc_act;
   logic [15:0] accel_cfg;
   logic [15:0] accel_act;
   logic [15:0] avg_cfg;
   logic [15:0] avg_act;
   logic [30:0] done_w;
   logic [30:0] near_w;
   logic [3:0] int_stat;
   logic [3:0] int_mask;
   logic [3:0] events;
   logic signed [31:0] err;
   logic signed [31:0] ref_step;
   logic signed [31:0] fb_step;
   logic [31:0] abs_err;
   logic [9:0] tick_cnt;
   logic tick;
   logic [15:0] stop_cnt;
   logic stopped;
   logic idle;
   logic pending;
   pspi_pkg::pspi_pulse_t mid;
   pspi_pkg::pspi_pulse_t acc_p;
   logic busy_a;
   logic busy_b;
   logic filt_idle;
   logic pos_mode;
   logic force_mode;
   logic inhibit;
   logic accept;
   logic done_cond;
   logic near_cond;
   logic [31:0] status;
   logic [31:0] next_rdata;
   logic hit;
   logic acc_ph;
   logic wr_en;

   assign acc_ph = PSEL & PENABLE & ~PREADY;
   assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

   // One wait state: the answer is registered so every bus output comes from a flop.
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY <= acc_ph;
         if (acc_ph)
         begin
            PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
            PSLVERR <= ~hit;
         end
      end
   end

   always_comb
   begin
      status = 32'h00000000;
      status[pspi_pkg::ST_DONE] = DONE_OUT;
      status[pspi_pkg::ST_NEAR] = NEAR_OUT;
      status[pspi_pkg::ST_INHIBIT] = inhibit;
      status[pspi_pkg::ST_FORCE] = FORCE_OUT;
      status[pspi_pkg::ST_POS] = pos_mode;
      status[pspi_pkg::ST_PENDING] = pending;
      status[pspi_pkg::ST_METHOD_LSB +: 4] = method_act;
      status[pspi_pkg::ST_TIMING_LSB +: 2] = timing_act;
      status[pspi_pkg::ST_ALLOC] = alloc_act;
      hit = 1'b1;
      next_rdata = 32'h00000000;
      case (PADDR)
         pspi_pkg::OFS_CTRL:
         begin
            next_rdata[pspi_pkg::CTRL_METHOD_LSB +: 4] = method_cfg;
            next_rdata[pspi_pkg::CTRL_TIMING_LSB +: 2] = timing_cfg;
            next_rdata[pspi_pkg::CTRL_ALLOC_BIT] = alloc_cfg;
         end
         pspi_pkg::OFS_RESTART: next_rdata = 32'h00000000;
         pspi_pkg::OFS_ACCEL: next_rdata = {16'h0000, accel_cfg};
         pspi_pkg::OFS_AVG: next_rdata = {16'h0000, avg_cfg};
         pspi_pkg::OFS_DONE_W: next_rdata = {1'b0, done_w};
         pspi_pkg::OFS_NEAR_W: next_rdata = {1'b0, near_w};
         pspi_pkg::OFS_STATUS: next_rdata = status;
         pspi_pkg::OFS_ERROR: next_rdata = err;
         pspi_pkg::OFS_INT_STAT: next_rdata = {28'h0000000, int_stat};
         pspi_pkg::OFS_INT_MASK: next_rdata = {28'h0000000, int_mask};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         method_cfg <= pspi_pkg::METHOD_RST;
         timing_cfg <= pspi_pkg::TIMING_RST;
         alloc_cfg <= 1'b0;
         accel_cfg <= pspi_pkg::TC_RST;
         avg_cfg <= pspi_pkg::TC_RST;
         done_w <= pspi_pkg::DONE_W_RST;
         near_w <= pspi_pkg::NEAR_W_RST;
         int_mask <= 4'h0;
      end
      else if (wr_en)
      begin
         case (PADDR)
            pspi_pkg::OFS_CTRL:
            begin
               method_cfg <= PWDATA[pspi_pkg::CTRL_METHOD_LSB +: 4];
               timing_cfg <= PWDATA[pspi_pkg::CTRL_TIMING_LSB +: 2];
               alloc_cfg <= PWDATA[pspi_pkg::CTRL_ALLOC_BIT];
            end
            pspi_pkg::OFS_ACCEL: accel_cfg <= PWDATA[15:0];
            pspi_pkg::OFS_AVG: avg_cfg <= PWDATA[15:0];
            pspi_pkg::OFS_DONE_W: done_w <= PWDATA[30:0];
            pspi_pkg::OFS_NEAR_W: near_w <= PWDATA[30:0];
            pspi_pkg::OFS_INT_MASK: int_mask <= PWDATA[3:0];
            default: ;
         endcase
      end
   end

   // Method, timing and allocation load only on restart.
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         method_act <= pspi_pkg::METHOD_RST;
         timing_act <= pspi_pkg::TIMING_RST;
         alloc_act <= 1'b0;
      end
      else if (wr_en && PADDR == pspi_pkg::OFS_RESTART && PWDATA[pspi_pkg::RESTART_BIT])
      begin
         method_act <= method_cfg;
         timing_act <= timing_cfg;
         alloc_act <= alloc_cfg;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!NRST || tick)
         tick_cnt <= 10'h000;
      else
         tick_cnt <= tick_cnt + 10'h001;
   end
   assign tick = tick_cnt == 10'(pspi_pkg::TICK_CYCLES - 1);

   always_ff @(posedge CLK)
   begin
      if (!NRST || FB_IN.pulse)
         stop_cnt <= 16'h0000;
      else if (!stopped)
         stop_cnt <= stop_cnt + 16'h0001;
   end
   assign stopped = stop_cnt >= 16'(STOP_CYCLES);
   assign filt_idle = ~busy_a & ~busy_b & ~mid.pulse & ~FILT_OUT.pulse;
   assign idle = stopped & ~REF_IN.pulse & filt_idle;
   assign pending = (accel_cfg != accel_act) || (avg_cfg != avg_act);

   // Swapping a time constant mid-move would distort travel, so wait for rest.
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         accel_act <= pspi_pkg::TC_RST;
         avg_act <= pspi_pkg::TC_RST;
      end
      else if (idle)
      begin
         accel_act <= accel_cfg;
         avg_act <= avg_cfg;
      end
   end

   always_comb
   begin
      case (method_act)
         pspi_pkg::M_POS: pos_mode = 1'b1;
         pspi_pkg::M_POS_INH: pos_mode = 1'b1;
         pspi_pkg::M_ISP_POS: pos_mode = CSEL_IN;
         pspi_pkg::M_POS_SPD: pos_mode = ~CSEL_IN;
         pspi_pkg::M_POS_FRC: pos_mode = ~CSEL_IN;
         default: pos_mode = 1'b0;
      endcase
      force_mode = (method_act == pspi_pkg::M_FORCE) ||
                   (method_act == pspi_pkg::M_POS_FRC && CSEL_IN);
      if (!alloc_act)
         inhibit = PCON_IN && method_act == pspi_pkg::M_POS_INH;
      else
         inhibit = INHIBIT_IN && (method_act == pspi_pkg::M_POS ||
                   method_act == pspi_pkg::M_ISP_POS || method_act == pspi_pkg::M_POS_SPD ||
                   method_act == pspi_pkg::M_POS_FRC);
      inhibit = inhibit & pos_mode;
      accept = REF_IN.pulse & ~inhibit;
      acc_p = '{pulse: accept, dir: REF_IN.dir};
   end

   pspi_smooth u_accel
   (
      .clk(CLK),
      .nrst(NRST),
      .tick(tick),
      .tc(accel_act),
      .in_p(acc_p),
      .out_p(mid),
      .busy(busy_a)
   );

   pspi_smooth u_avg
   (
      .clk(CLK),
      .nrst(NRST),
      .tick(tick),
      .tc(avg_act),
      .in_p(mid),
      .out_p(FILT_OUT),
      .busy(busy_b)
   );

   always_comb
   begin
      ref_step = 32'sh00000000;
      if (accept)
         ref_step = REF_IN.dir ? -32'sh00000001 : 32'sh00000001;
      fb_step = 32'sh00000000;
      if (FB_IN.pulse)
         fb_step = FB_IN.dir ? -32'sh00000001 : 32'sh00000001;
      abs_err = err[31] ? 32'(-err) : 32'(err);
      // Width test plus the selected timing condition.
      case (timing_act)
         pspi_pkg::T_FILTER: done_cond = filt_idle;
         pspi_pkg::T_INPUT: done_cond = ~REF_IN.pulse;
         default: done_cond = 1'b1;
      endcase
      done_cond = done_cond && pos_mode && abs_err < {1'b0, done_w};
      near_cond = pos_mode && abs_err < {1'b0, near_w};
   end

   always_ff @(posedge CLK)
   begin
      if (!NRST)
         err <= 32'sh00000000;
      else
         err <= err + ref_step - fb_step;
   end

   // Closed is high, open is low.
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         DONE_OUT <= 1'b0;
         NEAR_OUT <= 1'b0;
         FORCE_OUT <= 1'b0;
      end
      else
      begin
         DONE_OUT <= done_cond;
         NEAR_OUT <= near_cond;
         FORCE_OUT <= force_mode;
      end
   end

   always_comb
   begin
      events = 4'h0;
      events[pspi_pkg::INT_DONE] = done_cond & ~DONE_OUT;
      events[pspi_pkg::INT_NEAR] = near_cond & ~NEAR_OUT;
      events[pspi_pkg::INT_BLOCKED] = REF_IN.pulse & inhibit;
      events[pspi_pkg::INT_APPLIED] = idle & pending;
   end

   // A new event wins over a write-one clear in the same cycle.
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         int_stat <= 4'h0;
         IRQ <= 1'b0;
      end
      else
      begin
         if (wr_en && PADDR == pspi_pkg::OFS_INT_STAT)
            int_stat <= (int_stat & ~PWDATA[3:0]) | events;
         else
            int_stat <= int_stat | events;
         IRQ <= |(int_stat & int_mask);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   sequence s_bypass_accept;
      accel_act == 16'h0000 && avg_act == 16'h0000 && accept;
   endsequence
   sequence s_pulse_out;
      FILT_OUT.pulse && FILT_OUT.dir == $past(REF_IN.dir, 2);
   endsequence

   a_bypass_pass: assert property (s_bypass_accept |-> ##2 s_pulse_out)
      else $error("zero filter time did not pass the pulse through");
   a_param_hold: assert property ($changed(accel_act) || $changed(avg_act) |-> $past(idle))
      else $error("filter time changed while moving");
   a_done_width: assert property (DONE_OUT |-> $past(abs_err) < {1'b0, $past(done_w)})
      else $error("done asserted with error at or above width");
   a_done_open: assert property (!pos_mode |=> !DONE_OUT && !NEAR_OUT)
      else $error("done or near closed outside position control");
   a_done_input: assert property (DONE_OUT && $past(timing_act) == pspi_pkg::T_INPUT |-> $past(!REF_IN.pulse))
      else $error("done asserted while reference pulses arrive");
   a_near_width: assert property (pos_mode && abs_err < {1'b0, near_w} |=> NEAR_OUT)
      else $error("near not closed within width");
   a_inhibit_hold: assert property (inhibit && REF_IN.pulse && !FB_IN.pulse |=> err == $past(err))
      else $error("inhibited pulse was counted");
   a_pcon_only: assert property (!alloc_act && INHIBIT_IN && !PCON_IN |-> !inhibit)
      else $error("dedicated input acted under factory allocation");
   a_reassign_methods: assert property (inhibit && alloc_act |-> method_act inside {4'h1, 4'h5, 4'h7, 4'h8})
      else $error("inhibit honoured in wrong method");
   a_inhibit_mode: assert property (!pos_mode |-> !inhibit)
      else $error("inhibit active outside position control");
   a_force_mode: assert property (method_act == pspi_pkg::M_FORCE |=> FORCE_OUT)
      else $error("force mode not shown");
   a_err_count: assert property (accept && !REF_IN.dir && !FB_IN.pulse |=> err == $past(err) + 32'sh00000001)
      else $error("accepted pulse not counted once");
endmodule : pspi_settle
`default_nettype wire

// File: hdl/pspi_smooth.sv
/*
 One first-order smoothing stage for a reference pulse train; time constant in 0.1 ms ticks.
 Assumes the time constant only changes while the stage holds no backlog.
*/
`timescale 1ns/10ps
`default_nettype none
module pspi_smooth
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic [15:0] tc,
   input wire pspi_pkg::pspi_pulse_t in_p,
   output var pspi_pkg::pspi_pulse_t out_p,
   output logic busy
);
   logic signed [23:0] backlog;
   logic signed [23:0] step_in;
   logic signed [23:0] step_out;
   logic [23:0] mag;
   logic [31:0] acc;
   logic [31:0] tc_w;
   logic emit;

   always_comb
   begin
      mag = backlog[23] ? 24'(-backlog) : 24'(backlog);
      tc_w = {16'h0000, tc};
      emit = (tc != 16'h0000) && (backlog != 24'sh000000) && (acc >= tc_w);
      step_in = 24'sh000000;
      if (in_p.pulse)
         step_in = in_p.dir ? -24'sh000001 : 24'sh000001;
      step_out = 24'sh000000;
      if (emit)
         step_out = backlog[23] ? -24'sh000001 : 24'sh000001;
      busy = backlog != 24'sh000000;
   end

   // Pulses leave at a rate proportional to the backlog, so travel is kept exactly.
   always_ff @(posedge clk)
   begin
      if (!nrst || tc == 16'h0000)
      begin
         backlog <= 24'sh000000;
         acc <= 32'h00000000;
      end
      else
      begin
         backlog <= backlog + step_in - step_out;
         if (backlog == 24'sh000000)
            acc <= 32'h00000000;
         else
            acc <= acc + (tick ? {8'h00, mag} : 32'h00000000) - (emit ? tc_w : 32'h00000000);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         out_p <= '0;
      else if (tc == 16'h0000)
         out_p <= in_p;
      else
         out_p <= '{pulse: emit, dir: backlog[23]};
   end
endmodule : pspi_smooth
`default_nettype wire

// File: tb/pspi_host_model.sv
/*
 Host controller and motor model: sends reference pulses and travel pulses on request.
 Assumes one request at a time from the bench, synchronous to the drive clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pspi_host_model
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic to_fb,
   input wire logic [7:0] count,
   input wire logic dir,
   input wire logic [3:0] gap,
   output var pspi_pkg::pspi_pulse_t ref_p,
   output var pspi_pkg::pspi_pulse_t fb_p,
   output logic busy
);
   logic [7:0] left;
   logic [3:0] wait_c;
   logic sel;
   // The gap lets one model act as a fast or a slow controller.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         left <= 8'h00;
         wait_c <= 4'h0;
         sel <= 1'h0;
         ref_p <= '0;
         fb_p <= '0;
      end
      else
      begin
         ref_p.pulse <= 1'h0;
         fb_p.pulse <= 1'h0;
         if (go)
         begin
            left <= count;
            sel <= to_fb;
            wait_c <= 4'h0;
            if (to_fb)
               fb_p.dir <= dir;
            else
               ref_p.dir <= dir;
         end
         else if (left != 8'h00)
         begin
            if (wait_c == 4'h0)
            begin
               if (sel)
                  fb_p.pulse <= 1'h1;
               else
                  ref_p.pulse <= 1'h1;
               left <= left - 8'h01;
               wait_c <= gap;
            end
            else
               wait_c <= wait_c - 4'h1;
         end
      end
   end
   assign busy = (left != 8'h00);
endmodule : pspi_host_model
`default_nettype wire

// File: tb/pspi_settle_tb_top.sv
/*
 Self-checking bench for the settle block: APB register tasks and pulse scenarios.
 Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module pspi_settle_tb_top;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, v, w;
   logic pready, pslverr, done, near, frc, irq, busy, e;
   logic pcon = 1'h0, inh = 1'h0, csel = 1'h0;
   logic go = 1'h0, to_fb = 1'h0, mdir = 1'h0;
   logic [7:0] cnt = 8'h00;
   logic [3:0] gap = 4'h0, m;
   logic [11:0] c;
   logic byp_on = 1'h0, arm = 1'h0, dropped = 1'h0, pos, f, blk;
   logic [1:0] hist = 2'h0;
   pspi_pkg::pspi_pulse_t ref_p, fb_p, filt;
   int bad_count = 0, checks = 0, filt_n = 0, n;
   logic [14:0] tab [12] = '{{12'h00B, 3'h1}, {12'h00B, 3'h0}, {12'h00B, 3'h2},
      {12'h001, 3'h1}, {12'h101, 3'h2}, {12'h105, 3'h6}, {12'h107, 3'h2}, {12'h108, 3'h2},
      {12'h10B, 3'h2}, {12'h108, 3'h6}, {12'h105, 3'h2}, {12'h102, 3'h2}};

   always #50 clk = ~clk;

   pspi_settle #(.STOP_CYCLES(20)) i_pspi_settle
   (
      .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .REF_IN(ref_p), .FB_IN(fb_p), .PCON_IN(pcon), .INHIBIT_IN(inh), .CSEL_IN(csel),
      .FILT_OUT(filt), .DONE_OUT(done), .NEAR_OUT(near), .FORCE_OUT(frc), .IRQ(irq)
   );

   pspi_host_model i_pspi_host_model
   (
      .clk(clk), .nrst(nrst), .go(go), .to_fb(to_fb), .count(cnt), .dir(mdir),
      .gap(gap), .ref_p(ref_p), .fb_p(fb_p), .busy(busy)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
      int k;
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= wr_n;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'h1 && k < 50);
      if (k == 50)
         bad_count++;
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(1'h1, a, d, r, er);
   endtask : wr

   task automatic rdv(input logic [7:0] a, output logic [31:0] r);
      logic er;
      apb(1'h0, a, 32'h0, r, er);
   endtask : rdv

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      rdv(a, r);
      check(r, x);
   endtask : rd

   // Waits for the model, then three edges so the registered outputs settle.
   task automatic move(input logic fb, input logic [7:0] k, input logic d, input logic [3:0] g);
      int t;
      go <= 1'h1;
      to_fb <= fb;
      cnt <= k;
      mdir <= d;
      gap <= g;
      @(posedge clk);
      go <= 1'h0;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (busy === 1'h1 && t < 3000);
      repeat (3) @(posedge clk);
   endtask : move

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   always @(posedge clk)
   begin
      if (filt.pulse === 1'h1)
         filt_n <= filt_n + 1;
      if (byp_on)
         check(32'(filt.pulse), 32'(hist[1]));
      if (arm && done !== 1'h1)
         dropped <= 1'h1;
      hist <= {hist[0], ref_p.pulse};
   end

   initial
   begin
      #(3000000);
      bad_count++;
      complete_run();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      rd(pspi_pkg::OFS_CTRL, 32'h1);
      rd(pspi_pkg::OFS_ACCEL, 32'h0);
      rd(pspi_pkg::OFS_AVG, 32'h0);
      rd(pspi_pkg::OFS_DONE_W, 32'h7);
      rd(pspi_pkg::OFS_NEAR_W, 32'h40000000);
      rd(pspi_pkg::OFS_STATUS, 32'h113);
      wr(pspi_pkg::OFS_ERROR, 32'h5);
      rd(pspi_pkg::OFS_ERROR, 32'h0);
      apb(1'h0, 8'h30, 32'h0, v, e);
      check({v[30:0], e}, 32'h1);
      $display("test registers ended");
      // The near width is kept above the done width.
      wr(pspi_pkg::OFS_DONE_W, 32'h3);
      wr(pspi_pkg::OFS_NEAR_W, 32'hA);
      byp_on <= 1'h1;
      move(1'h0, 8'h0A, 1'h0, 4'h1);
      byp_on <= 1'h0;
      check(32'(filt_n), 32'hA);
      check({30'h0, near, done}, 32'h0);
      rd(pspi_pkg::OFS_ERROR, 32'hA);
      move(1'h1, 8'h01, 1'h0, 4'h0);
      check({30'h0, near, done}, 32'h2);
      move(1'h1, 8'h06, 1'h0, 4'h2);
      check({30'h0, near, done}, 32'h2);
      move(1'h1, 8'h01, 1'h0, 4'h0);
      check({30'h0, near, done}, 32'h3);
      move(1'h1, 8'h04, 1'h0, 4'h0);
      rd(pspi_pkg::OFS_ERROR, 32'hFFFFFFFE);
      check(32'(done), 32'h1);
      move(1'h0, 8'h02, 1'h0, 4'h0);
      $display("test widths ended");
      for (int t = 0; t < 3; t++)
      begin
         wr(pspi_pkg::OFS_CTRL, 32'h1 | 32'(t << 4));
         rdv(pspi_pkg::OFS_STATUS, v);
         check(32'(v[13:12]), (t == 0) ? 32'h0 : 32'(t - 1));
         wr(pspi_pkg::OFS_RESTART, 32'h1);
         rdv(pspi_pkg::OFS_STATUS, v);
         check(32'(v[13:12]), 32'(t));
         arm <= 1'h1;
         dropped <= 1'h0;
         move(1'h0, 8'h01, 1'h0, 4'h0);
         move(1'h1, 8'h01, 1'h0, 4'h0);
         arm <= 1'h0;
         check(32'(dropped), 32'(t != 0));
      end
      $display("test timing ended");
      wr(pspi_pkg::OFS_INT_MASK, 32'h4);
      for (int i = 0; i < 12; i++)
      begin
         c = tab[i][14:3];
         m = c[3:0];
         wr(pspi_pkg::OFS_CTRL, 32'(c));
         wr(pspi_pkg::OFS_RESTART, 32'h1);
         wr(pspi_pkg::OFS_INT_STAT, 32'hF);
         csel <= tab[i][2];
         inh <= tab[i][1];
         pcon <= tab[i][0];
         pos = m == 4'h1 || m == 4'hB || (m == 4'h5 && tab[i][2]) ||
            ((m == 4'h7 || m == 4'h8) && !tab[i][2]);
         f = m == 4'h2 || (m == 4'h8 && tab[i][2]);
         blk = pos && (c[8] ? tab[i][1] && (m == 4'h1 || m == 4'h5 || m == 4'h7 || m == 4'h8)
            : tab[i][0] && m == 4'hB);
         rdv(pspi_pkg::OFS_ERROR, v);
         move(1'h0, 8'h01, 1'h0, 4'h0);
         rdv(pspi_pkg::OFS_ERROR, w);
         if (pos)
            check(w - v, 32'(!blk));
         check(32'(irq), 32'(blk));
         rdv(pspi_pkg::OFS_STATUS, v);
         check(32'(v[4:2]), 32'({pos, f, blk}));
         check(32'(frc), 32'(f));
         if (pos && !blk)
            move(1'h1, 8'h01, 1'h0, 4'h0);
      end
      wr(pspi_pkg::OFS_CTRL, 32'hB);
      wr(pspi_pkg::OFS_RESTART, 32'h1);
      pcon <= 1'h1;
      move(1'h0, 8'h01, 1'h0, 4'h0);
      check(32'(irq), 32'h1);
      wr(pspi_pkg::OFS_INT_MASK, 32'h0);
      // The interrupt output is a register, so it lags the mask write by one more edge.
      @(posedge clk);
      check(32'(irq), 32'h0);
      wr(pspi_pkg::OFS_INT_STAT, 32'h4);
      rdv(pspi_pkg::OFS_INT_STAT, v);
      check(32'(v[2]), 32'h0);
      pcon <= 1'h0;
      wr(pspi_pkg::OFS_CTRL, 32'h1);
      wr(pspi_pkg::OFS_RESTART, 32'h1);
      $display("test inhibit ended");
      go <= 1'h1;
      to_fb <= 1'h1;
      cnt <= 8'h28;
      gap <= 4'h3;
      @(posedge clk);
      go <= 1'h0;
      wr(pspi_pkg::OFS_ACCEL, 32'h5);
      rdv(pspi_pkg::OFS_STATUS, v);
      check(32'(v[5]), 32'h1);
      while (busy === 1'h1)
         @(posedge clk);
      repeat (40) @(posedge clk);
      rdv(pspi_pkg::OFS_STATUS, v);
      check(32'(v[5]), 32'h0);
      rdv(pspi_pkg::OFS_INT_STAT, v);
      check(32'(v[3]), 32'h1);
      n = filt_n;
      move(1'h0, 8'h01, 1'h0, 4'h0);
      repeat (5) @(posedge clk);
      check(32'(filt_n - n), 32'h0);
      $display("test smoothing ended");
      complete_run();
   end
endmodule : pspi_settle_tb_top
`default_nettype wire
